// ### rtl/fhi_irq_status.sv
// Event status, masking and summary logic for two HDLC signaling channels
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module fhi_irq_status
	import fhi_pkg::*;
#(
	parameter int AW = 10,
	parameter int TX_DEPTH = QUEUE_DEPTH,
	parameter int RX_DEPTH = QUEUE_DEPTH
) (
	input wire logic pclk, // Bus clock, 40 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [AW-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic [3:0] ext_pending, // Pending from status registers 0..3
	input wire logic rx_slip_neg_tgl, // Toggles per negative receive slip
	input wire logic rx_slip_pos_tgl, // Toggles per positive receive slip
	input wire logic tx_slip_pos_tgl, // Toggles per positive transmit slip
	input wire logic tx_slip_neg_tgl, // Toggles per negative transmit slip
	input wire logic alarm_sim, // Alarm simulation active
	input wire logic pll_lock_in, // PLL locked level
	input wire logic [1:0] rx_byte_in, // Byte stored into receive queue
	input wire logic [1:0] rx_frame_ok, // Address match or opening flag
	input wire logic [1:0] rx_frame_end, // Status byte stored, frame over
	input wire logic [1:0] rx_drop, // Byte lost, receive queue full
	input wire logic [7:0] rx_addr, // Received address byte
	input wire logic [1:0][2:0] rx_stat, // Frame status bits 3 to 1
	input wire logic [1:0][6:0] rx_fill, // Bytes held in receive queue
	input wire logic [1:0][6:0] tx_fill, // Bytes held in transmit queue
	input wire logic [1:0] tx_last_bit, // Last frame bit has left
	input wire logic [1:0] tx_need_byte, // Transmitter asks for a byte
	input wire logic [1:0] tx_msg_end_cmd, // Message end command given
	input wire logic [1:0] hdlc_mode, // Channel in HDLC mode
	output logic irq, // Interrupt, active high
	output logic [1:0] tx_enable, // Transmitter and queue enabled
	output logic [1:0] tx_abort, // Send abort sequence, one cycle
	output logic [1:0] rx_accept, // Receive queue has room
	output logic [1:0] rx_frame_ovf // Current frame overflowed
);

	if (AW < 10 || TX_DEPTH < POOL_BYTES || TX_DEPTH > 127 || RX_DEPTH > 127)
	begin : g_bad_param
		$error("fhi_irq_status: unsupported parameters");
	end

	function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] idx);
		hit = (a == AW'({idx, 2'b00}));
	endfunction : hit

	// Bus phases; writes land on the completed access, read-clears on the capture edge
	logic setup;
	logic done;
	logic rd_take;
	logic wr_done;
	assign setup = psel & ~penable;
	assign done = psel & penable & pready;
	assign rd_take = setup & ~pwrite;
	assign wr_done = done & pwrite;

	// Address decode
	logic a_s4, a_s5, a_m4, a_m5, a_cfg, a_slip, a_gis, mapped;
	logic [1:0] a_bc, a_fs, a_ad;
	assign a_s4 = hit(paddr, IDX_STATUS_FOUR);
	assign a_s5 = hit(paddr, IDX_STATUS_FIVE);
	assign a_m4 = hit(paddr, IDX_MASK_FOUR);
	assign a_m5 = hit(paddr, IDX_MASK_FIVE);
	assign a_cfg = hit(paddr, IDX_CONFIG);
	assign a_slip = hit(paddr, IDX_RX_SLIP);
	assign a_gis = hit(paddr, IDX_GLOBAL_PENDING);
	assign a_bc = {hit(paddr, IDX_BYTE_COUNT_CH3), hit(paddr, IDX_BYTE_COUNT_CH2)};
	assign a_fs = {hit(paddr, IDX_FRAME_STATUS_CH3), hit(paddr, IDX_FRAME_STATUS_CH2)};
	assign a_ad = {hit(paddr, IDX_ADDRESS_CH3), hit(paddr, IDX_ADDRESS_CH2)};
	assign mapped = a_s4 | a_s5 | a_m4 | a_m5 | a_cfg | a_slip | a_gis | (|a_bc) | (|a_fs)
		| (|a_ad);

	// Clear on the edge that captures read data, so no event is lost between the two
	logic clr4, clr5, clr_slip;
	assign clr4 = rd_take & a_s4;
	assign clr5 = rd_take & a_s5;
	assign clr_slip = rd_take & a_slip;

	// Foreign-domain inputs through the three-stage filter
	logic [AI_W-1:0] ai_raw, ai_sy, ai_prev_r, ai_chg;
	assign ai_raw = {pll_lock_in, alarm_sim, tx_slip_neg_tgl, tx_slip_pos_tgl, rx_slip_pos_tgl,
		rx_slip_neg_tgl};
	assign ai_chg = ai_sy ^ ai_prev_r;

	fhi_sync #(.W(AI_W)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.din(ai_raw),
		.dout(ai_sy)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ai_prev_r <= '0;
		else
			ai_prev_r <= ai_sy;
	end

	// Slip events; alarm simulation entry raises both receive slips
	logic sim_rise, rsn_ev, rsp_ev, xsp_ev, xsn_ev;
	assign sim_rise = ai_chg[AI_ALARM_SIM] & ai_sy[AI_ALARM_SIM];
	assign rsn_ev = ai_chg[AI_RX_NEG] | sim_rise;
	assign rsp_ev = ai_chg[AI_RX_POS] | sim_rise;
	assign xsp_ev = ai_chg[AI_TX_POS];
	assign xsn_ev = ai_chg[AI_TX_NEG];

	// Per-channel event logic
	logic [1:0][EV_W-1:0] ev;
	logic [1:0][5:0] pool_cnt_r;
	logic [1:0][7:0] len_r, msg_len_r, addr_r;
	logic [1:0][1:0] rfs_cnt_r;
	logic [1:0][2:0] stat_r;
	logic [1:0] ovf_r, room_prev_r, tx_en_r;
	logic [1:0] reen;
	assign reen = {clr5, clr4}; // Underrun flag of ch2 lives in four, ch3 in five

	genvar c;
	generate
		for (c = 0; c < 2; c++)
		begin : g_ch
			logic pool_hit, rfs_hit, tx_empty, room;
			assign pool_hit = rx_byte_in[c] & (pool_cnt_r[c] == 6'(POOL_BYTES - 1));
			assign rfs_hit = rx_byte_in[c] & (rfs_cnt_r[c] == 2'd1);
			assign tx_empty = (tx_fill[c] == 7'h00);
			assign room = (8'(TX_DEPTH) - {1'b0, tx_fill[c]}) >= 8'(POOL_BYTES);

			// Event pulses
			assign ev[c][EV_RME] = rx_frame_end[c];
			assign ev[c][EV_RPF] = pool_hit & ~rx_frame_end[c];
			assign ev[c][EV_RFS] = rfs_hit;
			assign ev[c][EV_RDO] = rx_drop[c];
			assign ev[c][EV_ALLS] = tx_last_bit[c] & tx_empty & hdlc_mode[c];
			assign ev[c][EV_XDU] = tx_need_byte[c] & tx_en_r[c] & tx_empty
				& ~tx_msg_end_cmd[c];
			assign ev[c][EV_XPR] = room & ~room_prev_r[c];

			// Receive byte counting; pool count restarts per 32-byte block and per frame
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pool_cnt_r[c] <= '0;
					len_r[c] <= '0;
					msg_len_r[c] <= '0;
				end
				else if (rx_frame_end[c])
				begin
					pool_cnt_r[c] <= '0;
					len_r[c] <= '0;
					msg_len_r[c] <= len_r[c] + 8'(rx_byte_in[c]);
				end
				else if (rx_byte_in[c])
				begin
					pool_cnt_r[c] <= pool_hit ? 6'd0 : pool_cnt_r[c] + 6'd1;
					len_r[c] <= len_r[c] + 8'd1;
				end
			end

			// Frame start delay and capture of address and status
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					rfs_cnt_r[c] <= '0;
					addr_r[c] <= '0;
					stat_r[c] <= '0;
				end
				else if (rx_frame_ok[c])
					rfs_cnt_r[c] <= 2'(RFS_DELAY_BYTES);
				else if (rx_byte_in[c] && rfs_cnt_r[c] != 2'd0)
				begin
					rfs_cnt_r[c] <= rfs_cnt_r[c] - 2'd1;
					if (rfs_hit)
					begin
						addr_r[c] <= rx_addr;
						stat_r[c] <= rx_stat[c];
					end
				end
			end

			// Per-frame overflow mark, separate from the sticky interrupt flag
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					ovf_r[c] <= 1'b0;
				else if (rx_drop[c])
					ovf_r[c] <= 1'b1;
				else if (rx_frame_ok[c])
					ovf_r[c] <= 1'b0;
			end

			// Underrun parks the transmitter until its status register is read
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					tx_en_r[c] <= 1'b1;
					room_prev_r[c] <= 1'b0;
				end
				else
				begin
					room_prev_r[c] <= room;
					if (ev[c][EV_XDU])
						tx_en_r[c] <= 1'b0;
					else if (reen[c])
						tx_en_r[c] <= 1'b1;
				end
			end
		end
	endgenerate

	// Slips never touch the transmitter enables, so recovery needs no rewrite
	assign tx_enable = tx_en_r;

	// Raw set vectors for the two status registers
	logic [7:0] set4, set5;
	assign set4 = {xsp_ev, xsn_ev, ev[0][EV_RPF], ev[0][EV_XDU], ev[0][EV_ALLS], ev[0][EV_RDO],
		ev[0][EV_RFS], ev[0][EV_RME]};
	assign set5 = {ev[1][EV_RPF], ev[1][EV_XDU], ev[1][EV_ALLS], ev[1][EV_RDO], ev[1][EV_RFS],
		ev[1][EV_RME], ev[1][EV_XPR], ev[0][EV_XPR]};

	// Control registers
	logic [7:0] mask4_r, mask5_r;
	logic vis_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask4_r <= RST_MASK;
			mask5_r <= RST_MASK;
			vis_r <= 1'b0;
		end
		else if (wr_done)
		begin
			if (a_m4)
				mask4_r <= pwdata[7:0];
			if (a_m5)
				mask5_r <= pwdata[7:0];
			if (a_cfg)
				vis_r <= pwdata[CFG_VISIBLE];
		end
	end

	// Masked events are recorded only when the visible option is on; set beats clear
	logic [7:0] event_status_four_r, event_status_five_r, event_status_four_nxt, event_status_five_nxt;
	logic [1:0] slip_r, slip_nxt;
	assign event_status_four_nxt = (event_status_four_r & ~{8{clr4}}) | (set4 & (vis_r ? 8'hFF : ~mask4_r));
	assign event_status_five_nxt = (event_status_five_r & ~{8{clr5}}) | (set5 & (vis_r ? 8'hFF : ~mask5_r));
	assign slip_nxt = (slip_r & ~{2{clr_slip}}) | {rsp_ev, rsn_ev};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			event_status_four_r <= RST_STATUS;
			event_status_five_r <= RST_STATUS;
			slip_r <= '0;
		end
		else
		begin
			event_status_four_r <= event_status_four_nxt;
			event_status_five_r <= event_status_five_nxt;
			slip_r <= slip_nxt;
		end
	end

	// Summary: only unmasked bits count as pending
	logic [7:0] gis_r, gis_nxt;
	assign gis_nxt[SUM_EXT_LAST:0] = ext_pending | {(|slip_nxt), 3'b000};
	assign gis_nxt[SUM_FOUR] = |(event_status_four_nxt & ~mask4_r);
	assign gis_nxt[SUM_FIVE] = |(event_status_five_nxt & ~mask5_r);
	assign gis_nxt[SUM_LOCK] = ai_sy[AI_PLL];
	assign gis_nxt[7] = 1'b0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gis_r <= RST_SUMMARY;
			irq <= 1'b0;
			tx_abort <= '0;
			rx_accept <= '0;
			rx_frame_ovf <= '0;
		end
		else
		begin
			gis_r <= gis_nxt;
			irq <= |gis_nxt[SUM_FIVE:0];
			tx_abort <= {ev[1][EV_XDU], ev[0][EV_XDU]};
			rx_accept <= {rx_fill[1] < 7'(RX_DEPTH), rx_fill[0] < 7'(RX_DEPTH)};
			rx_frame_ovf <= ovf_r;
		end
	end

	// Read mux; byte count shows fill in bits 6:0, message length top bit in 7
	logic [7:0] rdata;
	assign rdata = a_s4 ? event_status_four_r : a_s5 ? event_status_five_r : a_m4 ? mask4_r : a_m5 ? mask5_r
		: a_cfg ? {7'h00, vis_r} : a_slip ? {6'h00, slip_r} : a_gis ? gis_r
		: a_bc[0] ? {msg_len_r[0][7], rx_fill[0]} : a_bc[1] ? {msg_len_r[1][7], rx_fill[1]}
		: a_fs[0] ? {2'b00, ovf_r[0], 1'b0, stat_r[0], 1'b0}
		: a_fs[1] ? {2'b00, ovf_r[1], 1'b0, stat_r[1], 1'b0}
		: a_ad[0] ? addr_r[0] : a_ad[1] ? addr_r[1] : 8'h00;

	// One wait-free access: data is captured in setup, ready for one access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup && !pwrite) ? {24'h00_0000, rdata} : '0;
		end
	end

	// Checks
	sequence s_rfs_seq(int k);
		rx_frame_ok[k] ##1 (~rx_byte_in[k] & ~rx_frame_ok[k]) ##1 (rx_byte_in[k] & ~rx_frame_ok[k])[*2];
	endsequence

	status_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		clr4 && set4 == 8'h00 |=> event_status_four_r == 8'h00)
		else $error("status four not cleared by read");
	masked_hidden_a: assert property (@(posedge pclk) disable iff (!presetn)
		vis_r && $stable(ext_pending) && $stable(mask4_r) && $stable(mask5_r) && slip_r == 2'b00
		&& ext_pending == 4'h0 && (event_status_four_r & ~mask4_r) == 8'h00
		&& (event_status_five_r & ~mask5_r) == 8'h00 |-> gis_r[SUM_FIVE:0] == 6'h00)
		else $error("masked event visible in summary");
	frame_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_rfs_seq(1) |-> ev[1][EV_RFS])
		else $error("frame start not two bytes after valid start");
	pool_full_a: assert property (@(posedge pclk) disable iff (!presetn)
		ev[1][EV_RPF] |-> rx_byte_in[1] && len_r[1][4:0] == 5'd31)
		else $error("pool full without 32 bytes");
	underrun_park_a: assert property (@(posedge pclk) disable iff (!presetn)
		ev[0][EV_XDU] |=> !tx_enable[0] && tx_abort[0])
		else $error("transmitter not parked on underrun");
	all_sent_a: assert property (@(posedge pclk) disable iff (!presetn)
		ev[0][EV_ALLS] && !mask4_r[S4_ALL_SENT_CH2] |=> event_status_four_r[S4_ALL_SENT_CH2]
		&& $past(tx_fill[0]) == 7'h00)
		else $error("all-sent flag wrong");
	irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq == (gis_r[SUM_FIVE:0] != 6'h00))
		else $error("interrupt does not track summary");
	rx_slip_a: assert property (@(posedge pclk) disable iff (!presetn)
		ai_chg[AI_RX_NEG] |=> slip_r[SLIP_NEG] && gis_r[SUM_EXT_LAST])
		else $error("negative receive slip lost");
	tx_slip_a: assert property (@(posedge pclk) disable iff (!presetn)
		xsp_ev && (vis_r || !mask4_r[S4_TX_SLIP_POS]) |=> event_status_four_r[S4_TX_SLIP_POS])
		else $error("positive transmit slip lost");
	apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup |=> pready ##1 !pready)
		else $error("bus answer not one cycle after setup");

endmodule : fhi_irq_status

// ### rtl/fhi_pkg.sv
// Constants and register map for the framer HDLC event status block
package fhi_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_STATUS_FOUR = 8'h60;
	localparam logic [7:0] IDX_STATUS_FIVE = 8'h61;
	localparam logic [7:0] IDX_MASK_FOUR = 8'h62;
	localparam logic [7:0] IDX_MASK_FIVE = 8'h63;
	localparam logic [7:0] IDX_CONFIG = 8'h64;
	localparam logic [7:0] IDX_RX_SLIP = 8'h65;
	localparam logic [7:0] IDX_BYTE_COUNT_CH2 = 8'h66;
	localparam logic [7:0] IDX_BYTE_COUNT_CH3 = 8'h67;
	localparam logic [7:0] IDX_FRAME_STATUS_CH2 = 8'h68;
	localparam logic [7:0] IDX_FRAME_STATUS_CH3 = 8'h69;
	localparam logic [7:0] IDX_ADDRESS_CH2 = 8'h6A;
	localparam logic [7:0] IDX_ADDRESS_CH3 = 8'h6B;
	localparam logic [7:0] IDX_GLOBAL_PENDING = 8'h6E;

	// Reset values
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_SUMMARY = 8'h00;

	// Per-channel event vector positions
	localparam int EV_RME = 0;
	localparam int EV_RFS = 1;
	localparam int EV_RDO = 2;
	localparam int EV_ALLS = 3;
	localparam int EV_XDU = 4;
	localparam int EV_RPF = 5;
	localparam int EV_XPR = 6;
	localparam int EV_W = 7;

	// Status four field positions
	localparam int S4_MSG_END_CH2 = 0;
	localparam int S4_FRAME_BEGIN_CH2 = 1;
	localparam int S4_OVERFLOW_CH2 = 2;
	localparam int S4_ALL_SENT_CH2 = 3;
	localparam int S4_UNDERRUN_CH2 = 4;
	localparam int S4_POOL_FULL_CH2 = 5;
	localparam int S4_TX_SLIP_NEG = 6;
	localparam int S4_TX_SLIP_POS = 7;

	// Status five field positions
	localparam int S5_POOL_READY_CH2 = 0;
	localparam int S5_POOL_READY_CH3 = 1;
	localparam int S5_MSG_END_CH3 = 2;
	localparam int S5_FRAME_BEGIN_CH3 = 3;
	localparam int S5_OVERFLOW_CH3 = 4;
	localparam int S5_ALL_SENT_CH3 = 5;
	localparam int S5_UNDERRUN_CH3 = 6;
	localparam int S5_POOL_FULL_CH3 = 7;

	// Other fields
	localparam int CFG_VISIBLE = 0;
	localparam int SLIP_NEG = 0;
	localparam int SLIP_POS = 1;
	localparam int SUM_EXT_LAST = 3;
	localparam int SUM_FOUR = 4;
	localparam int SUM_FIVE = 5;
	localparam int SUM_LOCK = 6;
	localparam int FST_OVERFLOW = 5;

	// Async input vector positions
	localparam int AI_RX_NEG = 0;
	localparam int AI_RX_POS = 1;
	localparam int AI_TX_POS = 2;
	localparam int AI_TX_NEG = 3;
	localparam int AI_ALARM_SIM = 4;
	localparam int AI_PLL = 5;
	localparam int AI_W = 6;

	// Queue sizes and byte counts
	localparam int POOL_BYTES = 32;
	localparam int RFS_DELAY_BYTES = 2;
	localparam int QUEUE_DEPTH = 64;

endpackage : fhi_pkg

// ### rtl/fhi_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module fhi_sync #(
	parameter int W = 1
) (
	input wire logic clk, // Sampling clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [W-1:0] din, // Foreign-domain levels
	output logic [W-1:0] dout // Filtered synchronous levels
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] agree;

	// Only stages two and three are compared; stage one feeds stage two alone
	assign agree = ~(s2_r ^ s3_r);

	// Shift chain
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end
		else
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Output moves only when the last two stages agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dout <= '0;
		else
			dout <= (s3_r & agree) | (dout & ~agree);
	end

endmodule : fhi_sync

// ### verif/fhi_hdlc_model.sv
// Far-side queue model: receive and transmit queue levels of both channels
`timescale 1ns/10ps
module fhi_hdlc_model (
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Reset, active low
	input wire logic [1:0] rx_byte_in, // Byte stored into receive queue
	input wire logic [1:0] rx_frame_end, // Frame handed over, queue drained
	input wire logic [1:0] tx_need_byte, // Transmitter takes one byte
	input wire logic [1:0] tx_load, // Host writes a 40-byte block
	output logic [1:0][6:0] rx_fill, // Receive queue level
	output logic [1:0][6:0] tx_fill // Transmit queue level
);
	// Levels move only on events; an empty queue never wraps below zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_fill <= '0;
			tx_fill <= '0;
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (rx_frame_end[c])
					rx_fill[c] <= 7'h00;
				else if (rx_byte_in[c])
					rx_fill[c] <= rx_fill[c] + 7'h01;
				if (tx_load[c])
					tx_fill[c] <= 7'h28;
				else if (tx_need_byte[c] && tx_fill[c] != 7'h00)
					tx_fill[c] <= tx_fill[c] - 7'h01;
			end
		end
	end
endmodule : fhi_hdlc_model

// ### verif/tb_framer_hdlc_interrupt_status.sv
// Self-checking bench for the HDLC event status block
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module tb_framer_hdlc_interrupt_status;
	import fhi_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_v;
	logic alarm_sim, pll_lock_in;
	logic rx_slip_neg_tgl, rx_slip_pos_tgl, tx_slip_pos_tgl, tx_slip_neg_tgl;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, rd_v;
	logic [3:0] ext_pending;
	logic [1:0] rx_byte_in, rx_frame_ok, rx_frame_end, rx_drop, tx_last_bit, tx_need_byte;
	logic [1:0] tx_load, tx_msg_end_cmd, hdlc_mode, tx_enable, tx_abort, rx_accept;
	logic [1:0] rx_frame_ovf;
	logic [7:0] rx_addr;
	logic [1:0][2:0] rx_stat;
	logic [1:0][6:0] rx_fill, tx_fill;
	int failures, tests_run, cyc;
	int slip_exp[4] = '{1, 2, 'h80, 'h40};

	fhi_irq_status dut (.*);
	fhi_hdlc_model far_end (.*);

	// Free-running bus clock
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Hang guard: the whole run needs well under this many cycles
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [9:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		`CHK(n, e, rd_v)
	endtask : rd

	// Raise one event input for n cycles, then drop all event inputs
	task automatic burst(input int k, input int n, input logic [1:0] m);
		@(posedge pclk);
		case (k)
			0: rx_byte_in <= m;
			1: tx_need_byte <= m;
			2: rx_drop <= m;
			3: rx_frame_ok <= m;
			4: rx_frame_end <= m;
			5: tx_load <= m;
			default: tx_last_bit <= m;
		endcase
		repeat (n) @(posedge pclk);
		{rx_byte_in, tx_need_byte, rx_drop, rx_frame_ok, rx_frame_end, tx_load} <= '0;
		tx_last_bit <= '0;
	endtask : burst

	// Main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, presetn, alarm_sim} = '0;
		{rx_slip_neg_tgl, rx_slip_pos_tgl, tx_slip_pos_tgl, tx_slip_neg_tgl} = '0;
		{rx_byte_in, rx_frame_ok, rx_frame_end, rx_drop, tx_last_bit, tx_need_byte} = '0;
		{tx_load, tx_msg_end_cmd} = '0;
		hdlc_mode = 2'b11;
		void'($urandom(50767));
		ext_pending = 4'($urandom);
		pll_lock_in = 1'($urandom);
		rx_addr = 8'($urandom);
		rx_stat = 6'($urandom);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(10'h1B8, {25'h0, pll_lock_in, 2'b10, ext_pending}, "summary");
		`CHK("irq", 1'b1, irq)
		rd(10'h184, 32'h3, "status five");
		rd(10'h184, 32'h0, "status five cleared");
		ext_pending <= 4'h0;
		repeat (3) @(posedge pclk);
		`CHK("irq idle", 1'b0, irq)
		$display("done: reset");
		// Underrun and all-sent on channel 2 with an empty transmit queue
		burst(6, 1, 2'b01);
		burst(1, 1, 2'b01);
		#1;
		`CHK("abort", 2'b01, tx_abort)
		`CHK("tx off", 2'b10, tx_enable)
		`CHK("irq", 1'b1, irq)
		@(posedge pclk);
		#1;
		`CHK("abort pulse", 2'b00, tx_abort)
		rd(10'h180, 32'h18, "status four");
		@(posedge pclk);
		#1;
		`CHK("tx on", 2'b11, tx_enable)
		// Empty queue with the end command given: no underrun
		@(posedge pclk);
		tx_msg_end_cmd <= 2'b10;
		burst(1, 1, 2'b10);
		tx_msg_end_cmd <= 2'b00;
		@(posedge pclk);
		`CHK("end cmd", 2'b11, tx_enable)
		`CHK("end cmd abort", 2'b00, tx_abort)
		$display("done: underrun");
		// Refill to 40 bytes, drain 8 back to back: room for a block again
		burst(5, 1, 2'b01);
		burst(1, 8, 2'b01);
		repeat (2) @(posedge pclk);
		rd(10'h184, 32'h1, "pool ready");
		rd(10'h180, 32'h0, "no underrun");
		$display("done: pool ready");
		// Receive frame on channel 3
		burst(3, 1, 2'b10);
		burst(0, 1, 2'b10);
		rd(10'h184, 32'h0, "one byte");
		burst(0, 1, 2'b10);
		rd(10'h184, 32'h8, "frame start");
		rd(10'h1AC, {24'h0, rx_addr}, "address");
		apb(1'b0, 10'h1A4, 32'h0);
		`CHK("frame status", rx_stat[1], rd_v[3:1])
		burst(0, 30, 2'b10);
		apb(1'b0, 10'h19C, 32'h0);
		`CHK("byte count", 7'd32, rd_v[6:0])
		`CHK("accept", 2'b11, rx_accept)
		burst(2, 1, 2'b10);
		apb(1'b0, 10'h1A4, 32'h0);
		`CHK("frame ovf", 1'b1, rd_v[FST_OVERFLOW])
		`CHK("frame ovf out", 2'b10, rx_frame_ovf)
		burst(4, 1, 2'b10);
		repeat (2) @(posedge pclk);
		rd(10'h184, 32'h94, "rx events");
		// Second frame: opening, one idle cycle, two bytes back to back
		burst(3, 1, 2'b10);
		burst(0, 2, 2'b10);
		rd(10'h184, 32'h8, "frame start again");
		$display("done: receive");
		// Masked overflow: dropped, then recorded once visible but silent
		apb(1'b1, 10'h18C, 32'h10);
		rd(10'h18C, 32'h10, "mask five");
		burst(2, 1, 2'b10);
		rd(10'h184, 32'h0, "masked dropped");
		apb(1'b1, 10'h190, 32'h1);
		burst(2, 1, 2'b10);
		repeat (2) @(posedge pclk);
		rd(10'h1B8, {25'h0, pll_lock_in, 6'h0}, "summary masked");
		`CHK("irq masked", 1'b0, irq)
		rd(10'h184, 32'h10, "masked visible");
		$display("done: masking");
		// Slips: each toggle is one event, crossing a synchroniser
		for (int i = 0; i < 4; i++)
		begin
			@(posedge pclk);
			case (i)
				0: rx_slip_neg_tgl <= 1'b1;
				1: rx_slip_pos_tgl <= 1'b1;
				2: tx_slip_pos_tgl <= 1'b1;
				default: tx_slip_neg_tgl <= 1'b1;
			endcase
			repeat (10) @(posedge pclk);
			rd(i < 2 ? 10'h194 : 10'h180, slip_exp[i], "slip");
		end
		`CHK("tx after slip", 2'b11, tx_enable)
		alarm_sim <= 1'b1;
		repeat (10) @(posedge pclk);
		rd(10'h194, 32'h3, "alarm sim");
		$display("done: slips");
		// Unmapped and read-only accesses, then random pending levels
		apb(1'b0, 10'h3FC, 32'h0);
		`CHK("unmapped err", 1'b1, err_v)
		`CHK("unmapped data", 32'h0, rd_v)
		apb(1'b1, 10'h1B8, 32'hFF);
		for (int i = 0; i < 4; i++)
		begin
			ext_pending <= 4'($urandom);
			repeat (3) @(posedge pclk);
			rd(10'h1B8, {25'h0, pll_lock_in, 2'b00, ext_pending}, "summary");
			`CHK("irq level", |ext_pending, irq)
		end
		$display("done: bus");
		report_and_stop();
	end
endmodule : tb_framer_hdlc_interrupt_status
